// ### shared/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
    // =========================================================
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int RESULT_BITS = 12;
    localparam int CODE_BITS = 4;
    localparam int CNT_BITS = 5;
    localparam logic [4:0] LAST_EDGE_CNT = 5'h0f;
    localparam logic [4:0] DONE_CNT = 5'h10;
    localparam logic [3:0] BIT_TOP = 4'hf;
    localparam logic [15:0] ALL_ONES = 16'hffff;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    // =========================================================
    // control word fields
    localparam int WRITE_BIT = 15;
    localparam int REPEAT_BIT = 14;
    localparam int CH0_BIT = 13;
    localparam int THERM_SEL_BIT = 5;
    localparam int OUTSIDE_REF_BIT = 2;
    localparam int THERM_AVG_BIT = 1;
    localparam int STANDBY_BIT = 0;
    // =========================================================
    // channel set and address codes
    localparam int NUM_INPUTS = 8;
    localparam int NUM_CHANNELS = 9;
    localparam logic [3:0] CODE_THERM_PLAIN = 4'h8;
    localparam logic [3:0] CODE_THERM_AVG = 4'h9;
    localparam logic [8:0] NO_CHANNELS = 9'h000;
    // =========================================================
    // thermal conversion timing
    localparam int SYS_CLK_PERIOD_NS = 25;
    localparam int THERM_CONV_MAX_NS = 100000;
    localparam int THERM_CONV_CYCLES = THERM_CONV_MAX_NS / SYS_CLK_PERIOD_NS;
    localparam int TIMER_BITS = 12;
    localparam logic [11:0] TIMER_ZERO = 12'h000;
    localparam logic [11:0] TIMER_ONE = 12'h001;
endpackage

// ### core/bit_sync.sv
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// two-flop level synchroniser
module bit_sync #(
    parameter int WIDTH = 1,
    parameter logic RST_VAL = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // next values: first stage read only by second
    always_comb begin
        nxt_meta = i_async;
        nxt_sync = meta_ff;
    end

    // registers
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_ff <= {WIDTH{RST_VAL}};
            sync_ff <= {WIDTH{RST_VAL}};
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign o_sync = sync_ff;
endmodule
`default_nettype wire

// ### core/adc_serial_control_readout.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - frame is 4-bit channel code then 12-bit result
// - chip select fall drives data out with the top code bit
// - remaining fifteen bits shift out on serial clock falling edges
// - data out floats again on the sixteenth falling edge
// - control bit 2 picks outside reference for next conversion
// - control bit 1 enables thermal averaging, only with bit 5 set
// - control bit 5 adds the thermal sensor to the channel set
// - thermal busy rises at chip select fall and covers the conversion
// - exactly one frame is honoured after thermal busy rises
// - later frames during busy ignored, control kept, data all ones
// - thermal conversion ends and busy falls within 100 us
// - standby write in honoured frame aborts thermal conversion at edge 16
// - data in shifts into control word on first 16 falling edges
// - control bit 15 gates replacing the control word
// - early chip select rise leaves control word unchanged, output floats
module adc_serial_control_readout #(
    parameter int CONV_CYCLES = adc_ctrl_pkg::THERM_CONV_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    input wire logic [11:0] i_conv_result,
    input wire logic [11:0] i_temp_result,
    output logic o_dout,
    output logic o_dout_oe_n,
    output logic o_thermal_conversion_active,
    output logic o_standby,
    output logic o_outside_reference_select,
    output logic o_thermal_averaging_enable,
    output logic [3:0] o_conv_channel,
    output logic o_conv_valid
);
    // =========================================================
    // link side: bit counter, cleared while chip select is high
    logic frame_rst;
    logic [4:0] bit_cnt_ff, nxt_bit_cnt;
    logic [15:0] in_shift_ff, nxt_in_shift;

    assign frame_rst = i_reset | i_cs_n;

    always_comb begin
        nxt_bit_cnt = bit_cnt_ff;
        nxt_in_shift = in_shift_ff;
        if (bit_cnt_ff != adc_ctrl_pkg::DONE_CNT) begin
            nxt_bit_cnt = bit_cnt_ff + 5'h01;
            nxt_in_shift = {in_shift_ff[14:0], i_din};
        end
    end

    // counter and input shifter
    always_ff @(negedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_ff <= 5'h00;
            in_shift_ff <= adc_ctrl_pkg::CTRL_RESET;
        end else begin
            bit_cnt_ff <= nxt_bit_cnt;
            in_shift_ff <= nxt_in_shift;
        end
    end

    // =========================================================
    // link side: control word, channel walk, result staging
    logic busy_lk, last_edge, ignore_now, cur_temp, commit, found;
    logic [11:0] temp_data_lk;
    logic [15:0] ctrl_ff, nxt_ctrl;
    logic [8:0] pending_ff, nxt_pending;
    logic [3:0] cur_code_ff, nxt_cur_code, pick;
    logic cur_valid_ff, nxt_cur_valid;
    logic [15:0] out_word_ff, nxt_out_word;
    logic lockout_ff, nxt_lockout;
    logic temp_pend_ff, nxt_temp_pend;
    logic [3:0] temp_code_ff, nxt_temp_code;
    logic abort_tgl_ff, nxt_abort_tgl;
    logic [15:0] word, eff_ctrl, tx_word;
    logic [8:0] sel, walk;

    assign last_edge = (bit_cnt_ff == adc_ctrl_pkg::LAST_EDGE_CNT) & ~i_cs_n;
    // frames after the honoured one are ignored
    assign ignore_now = lockout_ff & busy_lk;
    assign cur_temp = cur_valid_ff & cur_code_ff[3];
    assign word = {in_shift_ff[14:0], i_din};
    assign commit = last_edge & ~ignore_now & word[adc_ctrl_pkg::WRITE_BIT];

    // next-channel walk and frame-end updates
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_pending = pending_ff;
        nxt_cur_code = cur_code_ff;
        nxt_cur_valid = cur_valid_ff;
        nxt_out_word = out_word_ff;
        nxt_lockout = lockout_ff & busy_lk;
        nxt_temp_pend = temp_pend_ff;
        nxt_temp_code = temp_code_ff;
        nxt_abort_tgl = abort_tgl_ff;
        eff_ctrl = commit ? word : ctrl_ff;
        // input select bits 13..6 map to inputs 0..7
        for (int i = 0; i < adc_ctrl_pkg::NUM_INPUTS; i++) begin
            sel[i] = eff_ctrl[adc_ctrl_pkg::CH0_BIT - i];
        end
        sel[adc_ctrl_pkg::NUM_INPUTS] = eff_ctrl[adc_ctrl_pkg::THERM_SEL_BIT];
        walk = commit ? sel : pending_ff;
        if (!commit && walk == adc_ctrl_pkg::NO_CHANNELS &&
            eff_ctrl[adc_ctrl_pkg::REPEAT_BIT]) begin
            walk = sel;
        end
        found = 1'b0;
        pick = 4'h0;
        for (int i = adc_ctrl_pkg::NUM_CHANNELS - 1; i >= 0; i--) begin
            if (walk[i]) begin
                found = 1'b1;
                pick = 4'(i);
            end
        end
        if (last_edge && !ignore_now) begin
            nxt_ctrl = eff_ctrl;
            // code of the channel just converted
            nxt_out_word = {cur_code_ff, i_conv_result};
            if (!cur_valid_ff) begin
                nxt_out_word = adc_ctrl_pkg::ALL_ONES;
            end
            nxt_temp_pend = 1'b0;
            if (cur_temp) begin
                // honoured frame, lock out the rest of busy
                nxt_lockout = 1'b1;
                nxt_temp_pend = 1'b1;
                nxt_temp_code = cur_code_ff;
                // standby in the honoured frame aborts
                if (commit && word[adc_ctrl_pkg::STANDBY_BIT]) begin
                    nxt_abort_tgl = ~abort_tgl_ff;
                    nxt_lockout = 1'b0;
                    nxt_temp_pend = 1'b0;
                end
            end
            nxt_pending = walk;
            nxt_cur_valid = found & ~eff_ctrl[adc_ctrl_pkg::STANDBY_BIT];
            nxt_cur_code = pick;
            if (found) begin
                nxt_pending[pick] = 1'b0;
            end
            // averaging code only when the thermal channel is picked
            if (pick == adc_ctrl_pkg::CODE_THERM_PLAIN &&
                eff_ctrl[adc_ctrl_pkg::THERM_AVG_BIT]) begin
                nxt_cur_code = adc_ctrl_pkg::CODE_THERM_AVG;
            end
        end
    end

    // link registers; control word leaves reset all zeros
    always_ff @(negedge i_sclk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_ff <= adc_ctrl_pkg::CTRL_RESET;
            pending_ff <= adc_ctrl_pkg::NO_CHANNELS;
            cur_code_ff <= 4'h0;
            cur_valid_ff <= 1'b0;
            out_word_ff <= adc_ctrl_pkg::ALL_ONES;
            lockout_ff <= 1'b0;
            temp_pend_ff <= 1'b0;
            temp_code_ff <= adc_ctrl_pkg::CODE_THERM_PLAIN;
            abort_tgl_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            pending_ff <= nxt_pending;
            cur_code_ff <= nxt_cur_code;
            cur_valid_ff <= nxt_cur_valid;
            out_word_ff <= nxt_out_word;
            lockout_ff <= nxt_lockout;
            temp_pend_ff <= nxt_temp_pend;
            temp_code_ff <= nxt_temp_code;
            abort_tgl_ff <= nxt_abort_tgl;
        end
    end

    // =========================================================
    // serial output
    // word carried out; all ones when ignored or in standby
    always_comb begin
        tx_word = out_word_ff;
        if (temp_pend_ff) begin
            tx_word = {temp_code_ff, temp_data_lk};
        end
        if (ignore_now || ctrl_ff[adc_ctrl_pkg::STANDBY_BIT]) begin
            tx_word = adc_ctrl_pkg::ALL_ONES;
        end
    end

    // bit picked by counter, top bit shown at select fall
    assign o_dout = tx_word[adc_ctrl_pkg::BIT_TOP - bit_cnt_ff[3:0]];
    // float after edge 16 or when select rises
    assign o_dout_oe_n = frame_rst | (bit_cnt_ff == adc_ctrl_pkg::DONE_CNT);
    // reference choice for the next conversion
    assign o_outside_reference_select = ctrl_ff[adc_ctrl_pkg::OUTSIDE_REF_BIT];
    assign o_thermal_averaging_enable = ctrl_ff[adc_ctrl_pkg::THERM_AVG_BIT] &
        ctrl_ff[adc_ctrl_pkg::THERM_SEL_BIT];
    assign o_standby = ctrl_ff[adc_ctrl_pkg::STANDBY_BIT];
    assign o_conv_channel = cur_code_ff;
    assign o_conv_valid = cur_valid_ff;

    // =========================================================
    // crossings
    logic cs_s, temp_s, abort_s, start_conv, abort_ev;
    logic cs_prev_ff, nxt_cs_prev;
    logic abort_prev_ff, nxt_abort_prev;
    logic busy_ff, nxt_busy;
    logic [11:0] timer_ff, nxt_timer;
    logic [11:0] temp_res_ff, nxt_temp_res;
    bit_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_cs_sync (
        .i_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_async(i_cs_n),
        .o_sync(cs_s)
    );
    bit_sync #(.WIDTH(2), .RST_VAL(1'b0)) u_lk_sync (
        .i_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_async({cur_temp, abort_tgl_ff}),
        .o_sync({temp_s, abort_s})
    );
    // busy to link side; drops at once so a stopped sclk keeps no lockout
    bit_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_busy_sync (
        .i_clk(i_sclk),
        .i_reset(i_reset | ~busy_ff),
        .i_async(1'b1),
        .o_sync(busy_lk)
    );
    // result word is stable whenever busy reads low on the link side
    assign temp_data_lk = temp_res_ff;
    // =========================================================
    // system side: thermal busy timer
    assign start_conv = cs_prev_ff & ~cs_s & temp_s & ~busy_ff;
    assign abort_ev = abort_s ^ abort_prev_ff;
    // busy set at select fall, cleared at time limit or on a standby abort
    always_comb begin
        nxt_cs_prev = cs_s;
        nxt_abort_prev = abort_s;
        nxt_busy = busy_ff;
        nxt_timer = timer_ff;
        nxt_temp_res = temp_res_ff;
        if (start_conv) begin
            nxt_busy = 1'b1;
            nxt_timer = adc_ctrl_pkg::TIMER_ZERO;
        end else if (busy_ff) begin
            nxt_timer = timer_ff + adc_ctrl_pkg::TIMER_ONE;
            if (abort_ev) begin
                nxt_busy = 1'b0;
            end else if (timer_ff == 12'(CONV_CYCLES - 1)) begin
                nxt_busy = 1'b0;
                nxt_temp_res = i_temp_result;
            end
        end
    end

    // system registers
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            cs_prev_ff <= 1'b1;
            abort_prev_ff <= 1'b0;
            busy_ff <= 1'b0;
            timer_ff <= adc_ctrl_pkg::TIMER_ZERO;
            temp_res_ff <= adc_ctrl_pkg::RESULT_RESET;
        end else begin
            cs_prev_ff <= nxt_cs_prev;
            abort_prev_ff <= nxt_abort_prev;
            busy_ff <= nxt_busy;
            timer_ff <= nxt_timer;
            temp_res_ff <= nxt_temp_res;
        end
    end
    assign o_thermal_conversion_active = busy_ff;
    // =========================================================
    // checks
    property p_float_done;
        @(negedge i_sclk) disable iff (i_reset)
        bit_cnt_ff == adc_ctrl_pkg::DONE_CNT |-> o_dout_oe_n;
    endproperty
    a_float_done: assert property (p_float_done) else $error("dout driven after 16");
    property p_code_field;
        @(negedge i_sclk) disable iff (i_reset)
        last_edge && !ignore_now && cur_valid_ff && !cur_temp |=>
            out_word_ff[15:12] == $past(cur_code_ff);
    endproperty
    a_code_field: assert property (p_code_field) else $error("frame code wrong");
    property p_write_gate;
        @(negedge i_sclk) disable iff (i_reset)
        last_edge && !word[adc_ctrl_pkg::WRITE_BIT] |=> $stable(ctrl_ff);
    endproperty
    a_write_gate: assert property (p_write_gate) else $error("ctrl changed unwritten");
    property p_ignored;
        @(negedge i_sclk) disable iff (i_reset)
        ignore_now |=> $stable(ctrl_ff);
    endproperty
    a_ignored: assert property (p_ignored) else $error("ctrl changed in lockout");
    property p_mid_frame;
        @(negedge i_sclk) disable iff (i_reset)
        !last_edge |=> $stable(ctrl_ff);
    endproperty
    a_mid_frame: assert property (p_mid_frame) else $error("ctrl changed mid frame");
    property p_honoured;
        @(negedge i_sclk) disable iff (i_reset)
        last_edge && !ignore_now && cur_temp && !commit |=> lockout_ff || !$past(busy_lk);
    endproperty
    a_honoured: assert property (p_honoured) else $error("no lockout after frame");
    property p_busy_rise;
        @(posedge i_sys_clk) disable iff (i_reset)
        start_conv |=> busy_ff ##1 busy_ff;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");
    property p_busy_limit;
        @(posedge i_sys_clk) disable iff (i_reset)
        busy_ff |-> timer_ff < 12'(CONV_CYCLES);
    endproperty
    a_busy_limit: assert property (p_busy_limit) else $error("busy too long");
    property p_abort;
        @(posedge i_sys_clk) disable iff (i_reset)
        busy_ff && abort_ev && !start_conv |=> !busy_ff;
    endproperty
    a_abort: assert property (p_abort) else $error("abort ignored");
    c_commit: cover property (@(negedge i_sclk) disable iff (i_reset) commit);
    c_busy: cover property (@(posedge i_sys_clk) disable iff (i_reset) start_conv);
    c_abort: cover property (@(posedge i_sys_clk) disable iff (i_reset) abort_ev && busy_ff);
    c_lockout: cover property (@(negedge i_sclk) disable iff (i_reset) ignore_now && last_edge);
endmodule
`default_nettype wire

// ### dv/adc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// host serial port model
module adc_host_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din,
    input wire logic i_dout,
    input wire logic i_dout_oe_n
);
    logic last = 1'b0;
    // released line shows inverse of last bit seen
    wire logic line = i_dout_oe_n ? ~last : i_dout;
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_din = 1'b0;
    end
    // one frame of n clocks; sclk stands high outside frames
    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        o_cs_n = 1'b0;
        o_din = w[15];
        #40;
        for (int k = 0; k < n; k++) begin
            // read bit just ahead of each fall
            r = {r[14:0], line};
            last = line;
            o_sclk = 1'b0;
            #20;
            if (k < 15) o_din = w[14 - k];
            #20;
            o_sclk = 1'b1;
            // high half of the 80 ns period
            #40;
        end
        #40;
        o_cs_n = 1'b1;
        #120;
    endtask
endmodule
`default_nettype wire

// ### dv/adc_serial_control_readout_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// =========================================================
// bench for serial control and readout
module adc_serial_control_readout_tb_top;
    localparam int CONV = 200;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] conv_result = 12'h000;
    logic [11:0] temp_result = 12'h000;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic dout_oe_n;
    logic busy;
    logic standby;
    logic oref;
    logic avg;
    logic [3:0] conv_channel;
    logic conv_valid;
    int errors = 0;
    int samples_checked = 0;
    logic [15:0] seed = 16'h0004;
    logic [11:0] last_res;
    logic [15:0] r;
    logic [7:0] chs;
    logic [3:0] pc;
    logic [11:0] pr;
    logic pv;
    int n;
    adc_serial_control_readout #(.CONV_CYCLES(CONV)) u_dut (
        .i_sys_clk(sys_clk), .i_reset(reset), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_din(din), .i_conv_result(conv_result), .i_temp_result(temp_result),
        .o_dout(dout), .o_dout_oe_n(dout_oe_n), .o_thermal_conversion_active(busy),
        .o_standby(standby), .o_outside_reference_select(oref),
        .o_thermal_averaging_enable(avg), .o_conv_channel(conv_channel),
        .o_conv_valid(conv_valid)
    );
    adc_host_model u_host (
        .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout),
        .i_dout_oe_n(dout_oe_n)
    );
    // system clock 25 ns
    always #12.5 sys_clk = ~sys_clk;
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected frame: code then result
    function automatic logic [15:0] frame_of(input logic [3:0] c, input logic [11:0] v);
        return {c, v};
    endfunction
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one full frame with a fresh random conversion result
    task automatic xfer(input logic [15:0] w, output logic [15:0] rd);
        @(negedge sys_clk);
        seed = lfsr_next(seed);
        conv_result <= seed[11:0];
        last_res = seed[11:0];
        #7;
        u_host.frame(w, 16, rd);
    endtask
    // watchdog
    initial begin
        #2000000;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        check("oe_n", dout_oe_n, 1'b1);
        check("busy", busy, 1'b0);
        check("ctrl", {standby, oref, avg}, 3'b000);
        reset <= 1'b0;
        repeat (4) @(negedge sys_clk);
        // channel walk over random analog sets
        for (int t = 0; t < 3; t++) begin
            seed = lfsr_next(seed);
            chs = seed[7:0] | 8'h10;
            pv = seed[8];
            xfer({2'b10, chs, 3'b000, pv, 2'b10}, r);
            check("oref", oref, pv);
            check("avg", avg, 1'b0);
            check("oe_n", dout_oe_n, 1'b1);
            pv = 1'b0;
            for (int i = 0; i < 8; i++) begin
                if (chs[7 - i]) begin
                    check("chan", {conv_valid, conv_channel}, {1'b1, 4'(i)});
                    xfer(16'h0000, r);
                    if (pv) check("frame", r, frame_of(pc, pr));
                    pv = 1'b1;
                    pc = 4'(i);
                    pr = last_res;
                end
            end
            xfer(16'h0000, r);
            check("frame", r, frame_of(pc, pr));
            xfer(16'h0000, r);
            check("empty", r, 16'hffff);
            $display("test walk %0d done", t);
        end
        // write bit clear keeps the word
        pv = oref;
        xfer({1'b0, 15'h7fff}, r);
        check("oref", oref, pv);
        // short frame leaves the word alone
        u_host.frame({1'b1, 12'h000, ~pv, 2'b00}, 8, r);
        check("oref", oref, pv);
        check("oe_n", dout_oe_n, 1'b1);
        $display("test gating done");
        // thermal with averaging
        @(negedge sys_clk);
        pr = seed[15:4];
        temp_result <= pr;
        xfer(16'h8022, r);
        check("avg", avg, 1'b1);
        check("chan", {conv_valid, conv_channel}, 5'h19);
        xfer(16'h8004, r);
        check("busy", busy, 1'b1);
        check("oref", oref, 1'b1);
        xfer(16'h8000, r);
        check("locked", r, 16'hffff);
        check("oref", oref, 1'b1);
        n = 0;
        while (busy === 1'b1 && n < CONV + 10) begin
            @(negedge sys_clk);
            n++;
        end
        check("busy", busy, 1'b0);
        #400;
        xfer(16'h0000, r);
        check("temp", r, frame_of(4'h9, pr));
        $display("test thermal done");
        xfer(16'h8020, r);
        xfer(16'h8001, r);
        check("busy", busy, 1'b0);
        check("standby", standby, 1'b1);
        xfer(16'h0000, r);
        check("stby", r, 16'hffff);
        xfer(16'h8000, r);
        check("standby", standby, 1'b0);
        $display("test abort done");
        report_and_stop();
    end
endmodule
`default_nettype wire
